// *** rtl/twi_pkg.sv ***
// Package with register map, field positions and shared types of the two-wire controller.
package twi_pkg;
    localparam logic [3:0] ADDR_CTRL_LOW = 4'h0;
    localparam logic [3:0] ADDR_CTRL_HIGH = 4'h1;
    localparam logic [3:0] ADDR_STATUS = 4'h2;
    localparam logic [3:0] ADDR_MASK = 4'h3;
    localparam logic [3:0] ADDR_TX = 4'h4;
    localparam logic [3:0] ADDR_RX = 4'h5;
    localparam logic [3:0] ADDR_BAUD = 4'h6;
    localparam logic [3:0] ADDR_OWN = 4'h7;
    // Control low bit positions.
    localparam int CL_ON = 15;
    localparam int CL_REL = 12;
    localparam int CL_STRICT = 11;
    localparam int CL_TEN = 10;
    localparam int CL_GENERAL_CALL_ENABLE = 7;
    localparam int CL_CLOCK_STRETCH_ENABLE = 6;
    localparam int CL_ACKV = 5;
    localparam int CL_ACKRQ = 4;
    localparam int CL_RCVRQ = 3;
    localparam int CL_STOPRQ = 2;
    localparam int CL_RSTRQ = 1;
    localparam int CL_STARTRQ = 0;
    localparam logic [15:0] CL_RESET = 16'h1000;
    localparam logic [15:0] CL_WMASK = 16'hbfff;
    localparam logic [15:0] CH_WMASK = 16'h007b;
    localparam int CH_ADDRESS_HOLD_ENABLE = 1;
    localparam int CH_DATA_HOLD_ENABLE = 0;
    localparam logic [15:0] BAUD_RESET = 16'h00c3;
    localparam logic [9:0] OWN_RESET = 10'h050;

    typedef enum logic [3:0] {
        M_IDLE = 4'b0000,
        M_START = 4'b0001,
        M_RESTART = 4'b0010,
        M_STOP = 4'b0011,
        M_TX = 4'b0100,
        M_RX = 4'b0101,
        M_ACK = 4'b0110
    } mstate_t;

    typedef enum logic [2:0] {
        S_IDLE = 3'b000,
        S_ADDR = 3'b001,
        S_ADDR2 = 3'b010,
        S_RX = 3'b011,
        S_TX = 3'b100,
        S_ACKOUT = 3'b101,
        S_ACKIN = 3'b110
    } sstate_t;

    typedef struct packed {
        logic scl_oe;
        logic sda_oe;
    } pins_t;

    typedef struct packed {
        logic ack_received_status;
        logic master_tx_active;
        logic ack_time_flag;
        logic bus_collision_flag;
        logic general_call_seen;
        logic ten_bit_match_flag;
        logic write_collision_flag;
        logic receive_overflow_flag;
        logic data_not_address;
        logic stop_seen;
        logic start_seen;
        logic slave_read;
        logic rx_buffer_full;
        logic tx_buffer_full;
    } status_t;
endpackage : twi_pkg

// *** rtl/twi_ctrl.sv ***
// Two-wire master and slave controller with an Avalon-MM register slave.
//
// Overview of operation
// R1: Reserved address patterns never match as slave, apart from the general call address when enabled.
// R2: General call acknowledged only when enabled.
// R3: Enabled general call flags and proceeds receiving; in ten-bit mode it goes on to a second address byte instead.
// R4: Ten-bit upper pattern matches only ten-bit mode.
// R5: Clock stretching only with stretch enable set.
// R6: Clock release cleared at slave transmit, and at slave receive only with stretch enable set.
// R7: Master ack sequence drives stored ack value.
// R8: Hold modes use stored ack value.
// R9: Ack request runs sequence, hardware clears it.
// R10: Receive request takes one byte, self-clears.
// R11: Start, restart, stop requests self-clear when done.
// R12: Start/stop flags track bus, cleared when off.
// R13: Direction bit one for slave read.
// R14: Receive full set on byte, clear empty.
// R15: Transmit full while master byte shifts out; slave clears it when loading the byte.
// R16: Transmit write while the master engine runs or the buffer is full rejected, sets collision flag.
// R17: Mask bits make address bits don't-care.
// R18: Software clears strict bit before masking.
// R19: Software never loads baud reload below four.
// R20: Master data mismatch sets bus collision, aborts.
// R21: Received acknowledge recorded after each sent byte.
`timescale 1ns/100ps
module twi_ctrl
    import twi_pkg::*;
(
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe
);
    import twi_pkg::*;

    typedef struct packed {
        logic [1:0] scl_s;
        logic [1:0] sda_s;
        logic scl_p;
        logic sda_p;
        logic [15:0] ctl;
        logic [15:0] cth;
        logic [9:0] dont_care;
        logic [15:0] baud;
        logic [9:0] own;
        logic [7:0] tx;
        logic [7:0] rx;
        logic [7:0] sh;
        status_t st;
        mstate_t ms;
        logic [1:0] ph;
        logic [3:0] bits;
        logic [15:0] cnt;
        sstate_t ss;
        logic [3:0] sbits;
        logic [7:0] ssh;
        logic s_first;
        logic s_match;
        logic s_stretch;
        logic s_drive;
        pins_t pins;
        logic ack_q;
        logic [31:0] rd;
    } state_t;

    state_t s_q, s_d;

    // Masked compare of a received address against the own address.
    function automatic logic addr_hit(input logic [9:0] a, input logic [9:0] o, input logic [9:0] m);
        addr_hit = ((a ^ o) & ~m) == 10'h000;
    endfunction : addr_hit

    // Patterns that never match, whatever the mask; ten-bit upper pattern is handled apart.
    function automatic logic reserved7(input logic [6:0] a);
        reserved7 = (a[6:3] == 4'b0000) || (a[6:2] == 5'b11111); // see R1
    endfunction : reserved7

    logic scl, sda, scl_rise, scl_fall, start_ev, stop_ev;
    logic on, busy, take;

    always_comb begin
        scl = s_q.scl_s[1];
        sda = s_q.sda_s[1];
        scl_rise = scl & ~s_q.scl_p;
        scl_fall = ~scl & s_q.scl_p;
        start_ev = scl & s_q.scl_p & s_q.sda_p & ~sda;
        stop_ev = scl & s_q.scl_p & ~s_q.sda_p & sda;
        on = s_q.ctl[CL_ON];
        busy = (s_q.ms != M_IDLE) || (s_q.ss != S_IDLE);
        take = (read | write) & s_q.ack_q;
    end

    always_comb begin
        s_d = s_q;
        s_d.scl_s = {s_q.scl_s[0], scl_in};
        s_d.sda_s = {s_q.sda_s[0], sda_in};
        s_d.scl_p = scl;
        s_d.sda_p = sda;
        // One wait cycle per access keeps read data registered.
        s_d.ack_q = (read | write) & ~s_q.ack_q;
        s_d.rd = 32'h0000_0000;
        if (read & ~s_q.ack_q) begin
            unique case (address)
                ADDR_CTRL_LOW: s_d.rd = {16'h0000, s_q.ctl};
                ADDR_CTRL_HIGH: s_d.rd = {16'h0000, s_q.cth};
                ADDR_STATUS: s_d.rd = {16'h0000, s_q.st[13:11], 2'b00, s_q.st[10:0]};
                ADDR_MASK: s_d.rd = {22'h000000, s_q.dont_care};
                ADDR_TX: s_d.rd = {24'h000000, s_q.tx};
                ADDR_RX: s_d.rd = {24'h000000, s_q.rx};
                ADDR_BAUD: s_d.rd = {16'h0000, s_q.baud};
                ADDR_OWN: s_d.rd = {22'h000000, s_q.own};
                default: s_d.rd = 32'h0000_0000;
            endcase
        end
        if (read & take & address == ADDR_RX) begin
            s_d.st.rx_buffer_full = 1'b0; // see R14
        end
        if (write & take) begin
            unique case (address)
                ADDR_CTRL_LOW: s_d.ctl = (writedata[15:0] & CL_WMASK) | (s_q.ctl & ~CL_WMASK);
                ADDR_CTRL_HIGH: s_d.cth = writedata[15:0] & CH_WMASK;
                ADDR_MASK: s_d.dont_care = writedata[9:0];
                ADDR_BAUD: s_d.baud = writedata[15:0];
                ADDR_OWN: s_d.own = writedata[9:0];
                ADDR_STATUS: begin
                    if (!writedata[10]) s_d.st.bus_collision_flag = 1'b0;
                    if (!writedata[7]) s_d.st.write_collision_flag = 1'b0; // see R16
                    if (!writedata[6]) s_d.st.receive_overflow_flag = 1'b0;
                end
                ADDR_TX: begin
                    if (busy && s_q.ms != M_IDLE || s_q.st.tx_buffer_full) begin
                        s_d.st.write_collision_flag = 1'b1; // see R16
                    end else begin
                        s_d.tx = writedata[7:0];
                        s_d.st.tx_buffer_full = 1'b1; // see R15
                    end
                end
                default: ;
            endcase
        end

        // Bus condition flags.
        if (start_ev) begin
            s_d.st.start_seen = 1'b1; // see R12
            s_d.st.stop_seen = 1'b0;
        end
        if (stop_ev) begin
            s_d.st.stop_seen = 1'b1; // see R12
            s_d.st.start_seen = 1'b0;
        end

        // Master engine: each phase lasts baud+1 clocks, four phases per bit.
        if (s_q.ms != M_IDLE && s_q.cnt != 16'h0000) begin
            s_d.cnt = s_q.cnt - 16'h0001;
        end
        if (s_q.ms == M_IDLE && on) begin
            s_d.ph = 2'b00;
            s_d.cnt = s_q.baud;
            if (s_q.ctl[CL_STARTRQ]) s_d.ms = M_START;
            else if (s_q.ctl[CL_RSTRQ]) s_d.ms = M_RESTART;
            else if (s_q.ctl[CL_STOPRQ]) s_d.ms = M_STOP;
            else if (s_q.ctl[CL_RCVRQ]) begin
                s_d.ms = M_RX;
                s_d.bits = 4'h0;
            end else if (s_q.ctl[CL_ACKRQ]) s_d.ms = M_ACK;
            else if (s_q.st.tx_buffer_full && s_q.ss == S_IDLE) begin
                s_d.ms = M_TX;
                s_d.sh = s_q.tx;
                s_d.bits = 4'h0;
                s_d.st.master_tx_active = 1'b1;
            end
        end else if (s_q.ms != M_IDLE && s_q.cnt == 16'h0000) begin
            s_d.cnt = s_q.baud;
            s_d.ph = s_q.ph + 2'b01;
            unique case (s_q.ms)
                M_START: begin
                    // Phases: release both, pull data low, pull clock low.
                    s_d.pins = '{scl_oe: s_q.ph == 2'b10, sda_oe: s_q.ph != 2'b00};
                    if (s_q.ph == 2'b10) begin
                        s_d.ms = M_IDLE;
                        s_d.ctl[CL_STARTRQ] = 1'b0; // see R11
                    end
                end
                M_RESTART: begin
                    s_d.pins = '{scl_oe: s_q.ph == 2'b11, sda_oe: s_q.ph >= 2'b10};
                    if (s_q.ph == 2'b11) begin
                        s_d.ms = M_IDLE;
                        s_d.ctl[CL_RSTRQ] = 1'b0; // see R11
                    end
                end
                M_STOP: begin
                    s_d.pins = '{scl_oe: s_q.ph == 2'b00, sda_oe: s_q.ph != 2'b10};
                    if (s_q.ph == 2'b10) begin
                        s_d.pins = '{scl_oe: 1'b0, sda_oe: 1'b0};
                        s_d.ms = M_IDLE;
                        s_d.ctl[CL_STOPRQ] = 1'b0; // see R11
                    end
                end
                default: begin
                    // Bit phases: 0 set data, 1 raise clock, 2 sample, 3 lower clock.
                    s_d.pins.scl_oe = (s_q.ph == 2'b11);
                    if (s_q.ph == 2'b00) begin
                        s_d.pins.scl_oe = 1'b1;
                        if (s_q.ms == M_TX) s_d.pins.sda_oe = (s_q.bits == 4'h8) ? 1'b0 : ~s_q.sh[7];
                        else if (s_q.ms == M_ACK) s_d.pins.sda_oe = ~s_q.ctl[CL_ACKV]; // see R7
                        else s_d.pins.sda_oe = 1'b0;
                    end
                    if (s_q.ph == 2'b10) begin
                        if (s_q.ms == M_TX && s_q.bits < 4'h8 && s_q.sh[7] && !sda) begin
                            s_d.st.bus_collision_flag = 1'b1; // see R20
                            s_d.st.tx_buffer_full = 1'b0;
                            s_d.st.master_tx_active = 1'b0;
                            s_d.pins = '{scl_oe: 1'b0, sda_oe: 1'b0};
                            s_d.ms = M_IDLE;
                        end else if (s_q.ms == M_TX && s_q.bits == 4'h8) begin
                            s_d.st.ack_received_status = sda; // see R21
                        end else if (s_q.ms == M_RX) begin
                            s_d.sh = {s_q.sh[6:0], sda};
                        end else begin
                            s_d.sh = {s_q.sh[6:0], 1'b0};
                        end
                    end
                    if (s_q.ph == 2'b11) begin
                        s_d.bits = s_q.bits + 4'h1;
                        if (s_q.ms == M_ACK) begin
                            s_d.ms = M_IDLE;
                            s_d.ctl[CL_ACKRQ] = 1'b0; // see R9
                        end else if (s_q.ms == M_RX && s_q.bits == 4'h7) begin
                            s_d.ms = M_IDLE;
                            s_d.ctl[CL_RCVRQ] = 1'b0; // see R10
                            if (s_q.st.rx_buffer_full) s_d.st.receive_overflow_flag = 1'b1;
                            s_d.rx = s_q.sh;
                            s_d.st.rx_buffer_full = 1'b1; // see R14
                        end else if (s_q.ms == M_TX && s_q.bits == 4'h8) begin
                            s_d.ms = M_IDLE;
                            s_d.st.tx_buffer_full = 1'b0; // see R15
                            s_d.st.master_tx_active = 1'b0;
                        end
                    end
                end
            endcase
        end

        // Slave engine, driven by observed clock edges.
        s_d.st.ack_time_flag = (s_q.ss == S_ACKOUT) || (s_q.ss == S_ACKIN);
        if (on && s_q.ms == M_IDLE) begin
            if (scl_rise) begin
                s_d.ssh = {s_q.ssh[6:0], sda};
                s_d.sbits = s_q.sbits + 4'h1;
                if (s_q.ss == S_ACKIN) begin
                    s_d.st.ack_received_status = sda; // see R21
                    s_d.ss = sda ? S_IDLE : S_TX;
                    s_d.sbits = 4'h0;
                end
            end
            if (scl_fall) begin
                s_d.s_drive = 1'b0;
                unique case (s_q.ss)
                    S_ADDR, S_ADDR2, S_RX: begin
                        if (s_q.sbits == 4'h8) begin
                            logic [6:0] a7;
                            logic hit;
                            logic gc;
                            a7 = s_q.ssh[7:1];
                            gc = (s_q.ss == S_ADDR) && s_q.ssh == 8'h00 && s_q.ctl[CL_GENERAL_CALL_ENABLE]; // see R2
                            hit = 1'b0;
                            if (s_q.ss == S_ADDR && s_q.ctl[CL_TEN]) begin
                                hit = a7[6:2] == 5'b11110 && // see R4
                                      addr_hit({a7[1:0], 8'h00}, {s_q.own[9:8], 8'h00}, s_q.dont_care);
                            end else if (s_q.ss == S_ADDR) begin
                                hit = !reserved7(a7) && a7[6:2] != 5'b11110 && // see R1
                                      addr_hit({3'b000, a7}, {3'b000, s_q.own[6:0]}, s_q.dont_care); // see R17
                            end else if (s_q.ss == S_ADDR2) begin
                                hit = addr_hit({2'b00, s_q.ssh}, {2'b00, s_q.own[7:0]}, s_q.dont_care);
                            end
                            s_d.sbits = 4'h0;
                            if (s_q.ss == S_RX) begin
                                s_d.s_drive = s_q.cth[CH_DATA_HOLD_ENABLE] ? ~s_q.ctl[CL_ACKV] : ~s_q.st.rx_buffer_full; // see R8
                                if (s_q.st.rx_buffer_full) s_d.st.receive_overflow_flag = 1'b1;
                                else begin
                                    s_d.rx = s_q.ssh;
                                    s_d.st.rx_buffer_full = 1'b1; // see R14
                                end
                                s_d.st.data_not_address = 1'b1;
                                if (s_q.ctl[CL_CLOCK_STRETCH_ENABLE]) s_d.ctl[CL_REL] = 1'b0; // see R6
                                s_d.ss = S_ACKOUT;
                            end else if (hit || gc) begin
                                s_d.s_drive = s_q.cth[CH_ADDRESS_HOLD_ENABLE] ? ~s_q.ctl[CL_ACKV] : 1'b1; // see R8
                                s_d.st.general_call_seen = gc; // see R3
                                s_d.st.data_not_address = 1'b0;
                                s_d.st.slave_read = s_q.ssh[0] & ~gc; // see R13
                                s_d.st.ten_bit_match_flag = (s_q.ss == S_ADDR2);
                                s_d.s_match = 1'b1;
                                s_d.s_first = (s_q.ss == S_ADDR) && s_q.ctl[CL_TEN] && !s_q.ssh[0];
                                s_d.ss = S_ACKOUT;
                            end else begin
                                s_d.ss = S_IDLE;
                            end
                        end
                    end
                    S_ACKOUT: begin
                        s_d.sbits = 4'h0;
                        if (s_q.s_first) begin
                            s_d.s_first = 1'b0;
                            s_d.ss = S_ADDR2;
                        end else if (s_q.st.slave_read) begin
                            s_d.ss = S_TX;
                            s_d.ssh = s_q.tx;
                            s_d.s_drive = ~s_q.tx[7];
                            s_d.st.tx_buffer_full = 1'b0; // see R15
                            s_d.ctl[CL_REL] = 1'b0; // see R6
                        end else begin
                            s_d.ss = S_RX;
                        end
                    end
                    S_TX: begin
                        if (s_q.sbits == 4'h8) begin
                            s_d.ss = S_ACKIN;
                        end else begin
                            s_d.s_drive = ~s_q.ssh[7];
                        end
                    end
                    default: ;
                endcase
            end
            // Stretch only while enabled and release not yet granted.
            s_d.s_stretch = s_q.ctl[CL_CLOCK_STRETCH_ENABLE] && !s_q.ctl[CL_REL] && s_q.s_match && !scl; // see R5
            if (start_ev) begin
                s_d.ss = S_ADDR;
                s_d.sbits = 4'h0;
                s_d.s_match = 1'b0;
                s_d.s_drive = 1'b0;
            end
        end
        if (stop_ev) begin
            s_d.ss = S_IDLE;
            s_d.s_match = 1'b0;
            s_d.s_stretch = 1'b0;
            s_d.s_drive = 1'b0;
            s_d.st.general_call_seen = 1'b0;
            s_d.st.ten_bit_match_flag = 1'b0;
        end
        if (!on) begin
            s_d.st.start_seen = 1'b0; // see R12
            s_d.st.stop_seen = 1'b0;
            s_d.st.bus_collision_flag = 1'b0;
            s_d.ms = M_IDLE;
            s_d.ss = S_IDLE;
            s_d.pins = '{scl_oe: 1'b0, sda_oe: 1'b0};
            s_d.s_drive = 1'b0;
            s_d.s_stretch = 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            s_q <= '0;
            s_q.scl_s <= 2'b11;
            s_q.sda_s <= 2'b11;
            s_q.scl_p <= 1'b1;
            s_q.sda_p <= 1'b1;
            s_q.ctl <= CL_RESET;
            s_q.baud <= BAUD_RESET;
            s_q.own <= OWN_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    logic scl_oe_q, sda_oe_q;
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            scl_oe_q <= 1'b0;
            sda_oe_q <= 1'b0;
        end else begin
            scl_oe_q <= s_d.pins.scl_oe | s_d.s_stretch;
            sda_oe_q <= s_d.pins.sda_oe | s_d.s_drive;
        end
    end

    always_comb begin
        readdata = s_q.rd;
        waitrequest = (read | write) & ~s_q.ack_q;
        scl_out = 1'b0;
        sda_out = 1'b0;
        scl_oe = scl_oe_q;
        sda_oe = sda_oe_q;
    end
endmodule : twi_ctrl

// *** dv/twi_ctrl_assertions.sv ***
// Concurrent checks on the controller's register bus and pins.
`timescale 1ns/100ps
module twi_chk
    import twi_pkg::*;
(
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic [3:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [31:0] readdata,
    input wire logic waitrequest,
    input wire logic scl_in,
    input wire logic scl_out,
    input wire logic scl_oe,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe
);
    logic on_q;
    logic [9:0] mask_q;
    logic rd_ok;
    assign rd_ok = read && !waitrequest;
    // Shadows follow only accepted writes, so a refused cycle cannot move them.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            on_q <= 1'b0;
            mask_q <= 10'h000;
        end else if (write && !waitrequest && address == ADDR_CTRL_LOW) begin
            on_q <= writedata[CL_ON];
        end else if (write && !waitrequest && address == ADDR_MASK) begin
            mask_q <= writedata[9:0];
        end
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    sequence s_req;
        $rose(read || write);
    endsequence
    sequence s_answer;
        waitrequest ##1 !waitrequest;
    endsequence
    a_single_wait: assert property (s_req |-> s_answer)
        else $error("request not answered after one wait");
    a_mask_back: assert property (rd_ok && address == ADDR_MASK |-> readdata == {22'h000000, mask_q})
        else $error("mask readback wrong");
    a_unmapped_zero: assert property (rd_ok && address > ADDR_OWN |-> readdata == 32'h00000000)
        else $error("unmapped read not zero");
    a_off_flags: assert property (rd_ok && address == ADDR_STATUS && !on_q |-> readdata[4:3] == 2'b00)
        else $error("bus flags kept while off");
    a_status_gap: assert property (rd_ok && address == ADDR_STATUS |-> readdata[12:11] == 2'b00)
        else $error("unused status bits set");
    a_high_unused: assert property (rd_ok && address == ADDR_CTRL_HIGH |-> (readdata[15:0] & ~CH_WMASK) == 16'h0000)
        else $error("unused control bits set");
    a_open_drain: assert property (scl_out == 1'b0 && sda_out == 1'b0)
        else $error("pin driven high");
    a_off_quiet: assert property ((!on_q) [*3] |-> !scl_oe && !sda_oe)
        else $error("pins pulled while off");
endmodule : twi_chk
bind twi_ctrl twi_chk u_twi_chk(.ref_clk(ref_clk), .arst_n(arst_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .scl_in(scl_in), .scl_out(scl_out),
    .scl_oe(scl_oe), .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe));

// *** dv/twi_peer.sv ***
// Behavioural slave device on the two-wire bus.
`timescale 1ns/100ps
module twi_peer #(
    parameter logic [6:0] DEV_ADDR = 7'h2a,
    parameter logic [7:0] READ_BYTE = 8'ha5
) (
    input wire logic scl,
    input wire logic sda,
    output logic sda_pull,
    output logic [7:0] last_byte,
    output logic last_ack
);
    int cnt = -1;
    logic first = 1'b0;
    logic sel = 1'b0;
    logic rd = 1'b0;
    logic [7:0] sh = 8'h00;
    initial sda_pull = 1'b0;
    initial last_byte = 8'h00;
    initial last_ack = 1'b0;
    // A data edge while the clock is high frames a transfer.
    always @(negedge sda) begin
        if (scl) begin
            cnt = -1;
            first = 1'b1;
            sel = 1'b0;
            rd = 1'b0;
        end
    end
    always @(posedge sda) begin
        if (scl) begin
            cnt = -1;
            rd = 1'b0;
        end
    end
    always @(posedge scl) begin
        if (cnt >= 0 && cnt < 8) sh = {sh[6:0], sda};
        if (cnt == 8) last_ack = sda;
    end
    always @(negedge scl) begin
        cnt = cnt + 1;
        if (cnt == 8 && first) begin
            sel = sh[7:1] == DEV_ADDR;
            rd = sel && sh[0];
            sda_pull = sel;
        end else if (cnt == 8) begin
            last_byte = sh;
            sda_pull = sel && !rd;
        end else begin
            if (cnt == 9) begin
                cnt = 0;
                first = 1'b0;
                // A refused byte ends the read, so the line is free for stop.
                if (last_ack) rd = 1'b0;
            end
            sda_pull = rd && !READ_BYTE[7 - cnt];
        end
    end
endmodule : twi_peer

// *** dv/twi_ctrl_bench.sv ***
// Self-checking bench for the two-wire controller driving a slave peer.
`timescale 1ns/100ps
module twi_ctrl_bench;
    import twi_pkg::*;
    localparam logic [6:0] PEER = 7'h2a;
    localparam logic [7:0] RB = 8'ha5;
    logic ref_clk = 1'b0;
    logic arst_n = 1'b0;
    logic [3:0] address = 4'h0;
    logic read = 1'b0;
    logic write = 1'b0;
    logic [31:0] writedata = 32'h00000000;
    logic [31:0] readdata;
    logic waitrequest, scl_out, scl_oe, sda_out, sda_oe, pull, scl, sda, last_ack;
    logic [7:0] last_byte;
    logic [15:0] d;
    int bad_count = 0;
    int n_tests = 0;
    int cycles = 0;
    assign scl = !scl_oe;
    assign sda = !(sda_oe || pull);
    always #12.5 ref_clk = !ref_clk;
    twi_ctrl u_twi_ctrl(.ref_clk(ref_clk), .arst_n(arst_n), .address(address), .read(read), .write(write),
        .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest), .scl_in(scl), .scl_out(scl_out),
        .scl_oe(scl_oe), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe));
    twi_peer #(.DEV_ADDR(PEER), .READ_BYTE(RB)) u_twi_peer(.scl(scl), .sda(sda), .sda_pull(pull),
        .last_byte(last_byte), .last_ack(last_ack));
    task automatic end_of_test();
        if (bad_count == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_of_test
    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            end_of_test();
        end
    end
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask : check
    task automatic bus_wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge ref_clk);
        address <= a;
        writedata <= {16'h0000, v};
        write <= 1'b1;
        do @(posedge ref_clk); while (waitrequest !== 1'b0);
        write <= 1'b0;
    endtask : bus_wr
    task automatic bus_rd(input logic [3:0] a, output logic [15:0] v);
        @(posedge ref_clk);
        address <= a;
        read <= 1'b1;
        do @(posedge ref_clk); while (waitrequest !== 1'b0);
        v = readdata[15:0];
        read <= 1'b0;
    endtask : bus_rd
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
        bus_rd(a, d);
        check(d & m, e);
    endtask : rd_chk
    task automatic poll(input logic [3:0] a, input logic [15:0] m);
        for (int i = 0; i < 300; i++) begin
            bus_rd(a, d);
            if ((d & m) == 16'h0000) break;
        end
        check(d & m, 16'h0000);
    endtask : poll
    task automatic cond(input logic [15:0] v);
        bus_wr(ADDR_CTRL_LOW, 16'h9000 | v);
        poll(ADDR_CTRL_LOW, v);
    endtask : cond
    task automatic tx_done(input logic nak);
        poll(ADDR_STATUS, 16'h4001);
        rd_chk(ADDR_STATUS, 16'h8000, {nak, 15'h0000});
    endtask : tx_done
    task automatic send(input logic [7:0] b, input logic nak);
        bus_wr(ADDR_TX, {8'h00, b});
        rd_chk(ADDR_STATUS, 16'h0001, 16'h0001);
        tx_done(nak);
    endtask : send
    initial begin
        repeat (10) @(posedge ref_clk);
        arst_n <= 1'b1;
        rd_chk(ADDR_CTRL_LOW, 16'hffff, CL_RESET);
        rd_chk(ADDR_STATUS, 16'hffff, 16'h0000);
        rd_chk(4'hf, 16'hffff, 16'h0000);
        bus_wr(ADDR_MASK, 16'hffff);
        rd_chk(ADDR_MASK, 16'hffff, 16'h03ff);
        bus_wr(ADDR_MASK, 16'h0000);
        bus_wr(ADDR_CTRL_HIGH, 16'hffff);
        rd_chk(ADDR_CTRL_HIGH, 16'hffff, CH_WMASK);
        bus_wr(ADDR_CTRL_HIGH, 16'h0000);
        bus_wr(ADDR_BAUD, 16'h0004);
        cond(16'h0001);
        rd_chk(ADDR_STATUS, 16'h0018, 16'h0008);
        bus_wr(ADDR_TX, {8'h00, PEER, 1'b0});
        bus_wr(ADDR_TX, 16'h00ff);
        rd_chk(ADDR_STATUS, 16'h0081, 16'h0081);
        tx_done(1'b0);
        bus_wr(ADDR_STATUS, 16'h0000);
        rd_chk(ADDR_STATUS, 16'h0080, 16'h0000);
        send(8'h3c, 1'b0);
        check({8'h00, last_byte}, 16'h003c);
        cond(16'h0002);
        rd_chk(ADDR_STATUS, 16'h0018, 16'h0008);
        send({PEER, 1'b1}, 1'b0);
        for (int v = 0; v < 2; v++) begin
            cond(16'h0008);
            rd_chk(ADDR_STATUS, 16'h0002, 16'h0002);
            rd_chk(ADDR_RX, 16'h00ff, {8'h00, RB});
            rd_chk(ADDR_STATUS, 16'h0002, 16'h0000);
            bus_wr(ADDR_CTRL_LOW, 16'h9010 | (16'(v) << 5));
            poll(ADDR_CTRL_LOW, 16'h0010);
            check({15'h0000, last_ack}, 16'(v));
        end
        cond(16'h0004);
        rd_chk(ADDR_STATUS, 16'h0018, 16'h0010);
        cond(16'h0001);
        send({PEER ^ 7'h01, 1'b0}, 1'b1);
        cond(16'h0004);
        bus_wr(ADDR_CTRL_LOW, 16'h0000);
        rd_chk(ADDR_STATUS, 16'h0418, 16'h0000);
        end_of_test();
    end
endmodule : twi_ctrl_bench
